// ---- shared/irq_enable_cfg.svh ----
// Register offsets, implemented-bit masks and reset values of the enable bank
`ifndef IRQ_ENABLE_CFG_SVH
`define IRQ_ENABLE_CFG_SVH
`define IEB_ADDR_W      4
`define IEB_DATA_W      16
`define IEB_PRIO_W      3
`define IEB_OFF_EN2     4'h0
`define IEB_OFF_EN3     4'h1
`define IEB_OFF_EN4     4'h2
`define IEB_OFF_FLAG2   4'h4
`define IEB_OFF_FLAG3   4'h5
`define IEB_OFF_FLAG4   4'h6
`define IEB_OFF_PEND2   4'h8
`define IEB_OFF_PEND3   4'h9
`define IEB_OFF_PEND4   4'hA
`define IEB_MASK_EN2    16'hDFFF
`define IEB_MASK_EN3    16'h21FF
`define IEB_MASK_EN4    16'h00F6
`define IEB_RESET_EN    16'h0000
`define IEB_PRIO_OFF    3'h0
`endif

// ---- shared/irq_enable_pkg.sv ----
// Types shared by the enable bank
package irq_enable_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    BANK_EN2 = 2'b00,
    BANK_EN3 = 2'b01,
    BANK_EN4 = 2'b10,
    BANK_NONE = 2'b11
  } bank_e;
endpackage

// ---- design/enable_reg.sv ----
// One 16-bit enable register with implemented-bit mask
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module enable_reg #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic      [15:0] value
);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      value <= `IEB_RESET_EN;
    else if (clkEn && wrEn)
      value <= wrData & IMPL_MASK;
  end
endmodule // enable_reg

// ---- design/request_gate.sv ----
// Per-source gate of flag, enable and priority
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module request_gate #(
  parameter int N = 16
) (
  input  wire logic [N-1:0]   flag,
  input  wire logic [N-1:0]   enable,
  input  wire logic [3*N-1:0] prio,
  output logic      [N-1:0]   request
);
  always_comb
  begin
    for (int i = 0; i < N; i++)
      request[i] = flag[i] & enable[i]
        & (prio[3*i +: 3] != `IEB_PRIO_OFF);
  end
endmodule // request_gate

// ---- design/irq_enable_bank.sv ----
// Enable registers 2 to 4 with request gating
//
// Operation
// - Reg2 high byte: timer6, dma4, oc8-5, ic6
// - Reg2 low byte: ic5-3, dma3, can1, spi2
// - Reg3 bits 13 dma5, 8 can2 event
// - Reg3 low byte: can2 rx, ext4, ext3, timers
// - Reg4 low byte only: tx, dma, uart errors
// - Unimplemented bits read as zero
// - Enable bits read/write, reset to zero
// - Enable one passes request, zero blocks
// - Flag reads one regardless of enable
// - Priority 000 disables, 111 highest
`timescale 1ns/1ps
`include "irq_enable_cfg.svh"
module irq_enable_bank (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  input  wire logic [15:0] flag2,
  input  wire logic [15:0] flag3,
  input  wire logic [15:0] flag4,
  input  wire logic [47:0] prio2,
  input  wire logic [47:0] prio3,
  input  wire logic [47:0] prio4,
  output logic      [15:0] request2,
  output logic      [15:0] request3,
  output logic      [15:0] request4
);
  logic [15:0] en2;
  logic [15:0] en3;
  logic [15:0] en4;
  logic [15:0] rdData_nxt;

  function automatic irq_enable_pkg::bank_e decodeEn(input logic [3:0] a);
    case (a)
      `IEB_OFF_EN2: decodeEn = irq_enable_pkg::BANK_EN2;
      `IEB_OFF_EN3: decodeEn = irq_enable_pkg::BANK_EN3;
      `IEB_OFF_EN4: decodeEn = irq_enable_pkg::BANK_EN4;
      default:      decodeEn = irq_enable_pkg::BANK_NONE;
    endcase
  endfunction

  irq_enable_pkg::bank_e wrSel;
  assign wrSel = decodeEn(regAddr);

  enable_reg #(.IMPL_MASK(`IEB_MASK_EN2)) uEn2 (
    .clock  (clock),
    .sys_rst(sys_rst),
    .clkEn  (clkEn),
    .wrEn   (regWrite && wrSel == irq_enable_pkg::BANK_EN2),
    .wrData (regWrData),
    .value  (en2)
  );
  enable_reg #(.IMPL_MASK(`IEB_MASK_EN3)) uEn3 (
    .clock  (clock),
    .sys_rst(sys_rst),
    .clkEn  (clkEn),
    .wrEn   (regWrite && wrSel == irq_enable_pkg::BANK_EN3),
    .wrData (regWrData),
    .value  (en3)
  );
  enable_reg #(.IMPL_MASK(`IEB_MASK_EN4)) uEn4 (
    .clock  (clock),
    .sys_rst(sys_rst),
    .clkEn  (clkEn),
    .wrEn   (regWrite && wrSel == irq_enable_pkg::BANK_EN4),
    .wrData (regWrData),
    .value  (en4)
  );

  logic [15:0] req2;
  logic [15:0] req3;
  logic [15:0] req4;

  request_gate #(.N(16)) uGate2 (
    .flag   (flag2),
    .enable (en2),
    .prio   (prio2),
    .request(req2)
  );
  request_gate #(.N(16)) uGate3 (
    .flag   (flag3),
    .enable (en3),
    .prio   (prio3),
    .request(req3)
  );
  request_gate #(.N(16)) uGate4 (
    .flag   (flag4),
    .enable (en4),
    .prio   (prio4),
    .request(req4)
  );

  // Registered requests toward the processor
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      request2 <= 16'h0000;
      request3 <= 16'h0000;
      request4 <= 16'h0000;
    end
    else if (clkEn)
    begin
      request2 <= req2;
      request3 <= req3;
      request4 <= req4;
    end
  end

  // Read multiplexer
  always_comb
  begin
    case (regAddr)
      `IEB_OFF_EN2:   rdData_nxt = en2;
      `IEB_OFF_EN3:   rdData_nxt = en3;
      `IEB_OFF_EN4:   rdData_nxt = en4;
      `IEB_OFF_FLAG2: rdData_nxt = flag2 & `IEB_MASK_EN2;
      `IEB_OFF_FLAG3: rdData_nxt = flag3 & `IEB_MASK_EN3;
      `IEB_OFF_FLAG4: rdData_nxt = flag4 & `IEB_MASK_EN4;
      `IEB_OFF_PEND2: rdData_nxt = req2;
      `IEB_OFF_PEND3: rdData_nxt = req3;
      `IEB_OFF_PEND4: rdData_nxt = req4;
      default:        rdData_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      regRdData <= 16'h0000;
    else if (clkEn)
      regRdData <= regRead ? rdData_nxt : 16'h0000;
  end
endmodule // irq_enable_bank

// ---- sim/irq_src_model.sv ----
// Peripheral source model: flag levels and priority fields
`timescale 1ns/1ps
module irq_src_model (
  input  wire logic        clock,
  input  wire logic [31:0] rnd,
  output logic      [15:0] flag,
  output logic      [47:0] prio
);
  always_ff @(posedge clock)
  begin
    flag <= rnd[31:16];
    prio <= {rnd[15:0], rnd};
  end
endmodule // irq_src_model

// ---- sim/irq_enable_bank_assertions.sv ----
// Checker of enable bank reads and requests
`timescale 1ns/1ps
module irq_enable_bank_chk (
  input wire logic        clock, sys_rst, clkEn, regWrite, regRead,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData, regRdData, flag2, request2,
  input wire logic [47:0] prio2
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence rd0; clkEn && regRead && regAddr == 4'h0; endsequence
  sequence wr0; clkEn && regWrite && regAddr == 4'h0; endsequence
  AST_EN2: assert property (rd0 |=> !regRdData[13])
    else $error("bad bit");
  AST_EN3: assert property (clkEn && regRead && regAddr == 4'h1 |=>
    (regRdData & 16'hDE00) == 0) else $error("bad bits");
  AST_EN4: assert property (clkEn && regRead && regAddr == 4'h2 |=>
    (regRdData & 16'hFF09) == 0) else $error("bad bits");
  AST_IDLE: assert property (clkEn && !regRead |=> regRdData == 0)
    else $error("data idle");
  AST_WRRD: assert property (wr0 ##1 rd0 |=>
    regRdData == ($past(regWrData, 2) & 16'hDFFF)) else $error("rw");
  AST_RST: assert property ($fell(sys_rst) |-> request2 == 0)
    else $error("reset");
  AST_PRIO: assert property (clkEn && prio2[2:0] == 3'h0 |=>
    !request2[0]) else $error("prio");
  AST_REQ: assert property (clkEn |=>
    (request2 & ~$past(flag2)) == 0) else $error("flag");
endmodule // irq_enable_bank_chk
bind irq_enable_bank irq_enable_bank_chk u_chk (.*);

// ---- sim/tb_irq_enable_bank.sv ----
// Bench of the interrupt enable bank
`timescale 1ns/1ps
module tb_irq_enable_bank;
  logic clock = 0, sys_rst = 1, regWrite = 0, regRead = 0, clkEn = 1;
  logic [3:0] regAddr = 0;
  logic [15:0] regWrData = 0, regRdData, q2, q3, q4, f2, f3, f4;
  logic [47:0] p2, p3, p4;
  logic [31:0] rs = 32'hDA4BC0CA, d;
  logic [15:0] msk[3] = '{16'hDFFF, 16'h21FF, 16'h00F6}, en[3], e[3];
  int mismatches = 0, checked = 0, cyc = 0;
  initial forever #50 clock = ~clock;
  irq_enable_bank dut_u (.clock, .sys_rst, .clkEn, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .flag2(f2), .flag3(f3),
    .flag4(f4), .prio2(p2), .prio3(p3), .prio4(p4), .request2(q2),
    .request3(q3), .request4(q4));
  irq_src_model s2 (.clock, .rnd(rs), .flag(f2), .prio(p2));
  irq_src_model s3 (.clock, .rnd(~rs), .flag(f3), .prio(p3));
  irq_src_model s4 (.clock, .rnd({rs[7:0], rs[31:8]}), .flag(f4),
    .prio(p4));
  function logic [31:0] xs(logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction
  function logic [15:0] ex(logic [15:0] f, n, logic [47:0] p);
    for (int i = 0; i < 16; i++) ex[i] = f[i] & n[i] & (p[3*i+:3] != 0);
  endfunction
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(logic [15:0] s, x);
    checked++;
    if (s !== x)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %h %h", $time, s, x);
    end
  endtask
  task wr(int a, logic [15:0] v);
    regAddr <= 4'(a); regWrData <= v; regWrite <= 1; @(posedge clock);
    regWrite <= 0;
  endtask
  task rd(int a, logic [15:0] x);
    regAddr <= 4'(a); regRead <= 1; @(posedge clock); regRead <= 0;
    @(negedge clock); chk(regRdData, x); @(posedge clock);
  endtask
  always @(posedge clock) if (++cyc > 2000)
  begin
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) rd(i, 0);
    for (int k = 0; k < 9; k++)
      for (int i = 0; i < 3; i++)
      begin
        d = k ? xs(rs) : '1;
        rs <= d;
        wr(i, d[15:0]);
        en[i] = d[15:0] & msk[i];
        rd(i, en[i]);
      end
    wr(3, '1);
    wr(4, '1);
    for (int i = 0; i < 4; i++) rd(i, i < 3 ? en[i] : 0);
    for (int k = 0; k < 300; k++)
    begin
      @(negedge clock);
      if (k > 0)
      begin
        chk(q2, e[0]);
        chk(q3, e[1]);
        chk(q4, e[2]);
      end
      e = '{ex(f2, en[0], p2), ex(f3, en[1], p3), ex(f4, en[2], p4)};
      rs = xs(rs);
    end
    repeat (2) @(posedge clock);
    rd(4, f2 & msk[0]);
    rd(8, ex(f2, en[0], p2));
    clkEn <= 0;
    wr(0, 16'h0000);
    clkEn <= 1;
    rd(0, en[0]);
    sys_rst <= 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    en = '{default: '0};
    for (int i = 0; i < 3; i++) rd(i, en[i]);
    test_done;
  end
endmodule // tb_irq_enable_bank
